// ==== bench/pgs_host_model.sv ====
// Host side model: loads program and expansion words into the sequencer.
// Assumes the sequencer takes a write on any rising edge where the strobe is high.
`timescale 1ns/1ps
module pgs_host_model
   import pgs_pkg::*;
#(
   parameter int NUM_EXP = 1
) (
   input wire logic ref_clk_i,
   output logic prog_we_o,
   output logic [PC_W-1:0] prog_addr_o,
   output pgs_word_t prog_wdata_o,
   output logic [NUM_EXP-1:0] exp_we_o,
   output logic [EXP_DATA_W-1:0] exp_wdata_o
);
   initial begin
      prog_we_o = 1'b0;
      prog_addr_o = 12'h000;
      prog_wdata_o = '0;
      exp_we_o = '0;
      exp_wdata_o = '0;
   end

   // One word a call; the lines show the inverse once released, so a late
   // sample of stale data cannot pass for a good write.
   task automatic write_word(input logic [PC_W-1:0] addr, input pgs_word_t w,
                             input logic [EXP_DATA_W-1:0] ew);
      @(posedge ref_clk_i);
      prog_we_o <= 1'b1;
      exp_we_o <= '1;
      prog_addr_o <= addr;
      prog_wdata_o <= w;
      exp_wdata_o <= ew;
      @(posedge ref_clk_i);
      prog_we_o <= 1'b0;
      exp_we_o <= '0;
      prog_addr_o <= ~addr;
      prog_wdata_o <= ~w;
      exp_wdata_o <= ~ew;
   endtask
endmodule

// ==== bench/pgs_sequencer_tb_top.sv ====
// Top testbench: loads a short program, runs it and checks the outputs.
// Assumes the default step of ten minor ticks and one expansion card.
`timescale 1ns/1ps
module pgs_sequencer_tb_top
   import pgs_pkg::*;
;
   logic ref_clk, rstn, we, pc_load, start, stop, arm_wait, imb_arm, coarse;
   logic ext_sel, ext_clk, imb_trig, marker, running, waiting, armed;
   logic [PC_W-1:0] addr, load_addr, pc;
   logic [STB_N-1:0] qual, strobe;
   logic [DATA_W-1:0] data;
   logic [PARAM_W-1:0] rep_left;
   logic [0:0] exp_we;
   logic [EXP_DATA_W-1:0] exp_wdata, exp_data;
   pgs_word_t wdata;
   pgs_strobe_cfg_t [STB_N-1:0] scfg;
   pgs_word_t prog [4];
   logic [EXP_DATA_W-1:0] exp_w [4];
   int error_cnt = 0;
   int checked = 0;
   int n;
   int hi;

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   pgs_host_model #(.NUM_EXP(1)) u_pgs_host_model (.ref_clk_i(ref_clk),
      .prog_we_o(we), .prog_addr_o(addr), .prog_wdata_o(wdata),
      .exp_we_o(exp_we), .exp_wdata_o(exp_wdata));

   pgs_sequencer #(.NUM_EXP(1), .TICKS(10)) u_pgs_sequencer (
      .ref_clk_i(ref_clk), .rstn_i(rstn), .prog_we_i(we),
      .prog_addr_i(addr), .prog_wdata_i(wdata), .exp_we_i(exp_we),
      .exp_wdata_i(exp_wdata), .strobe_cfg_i(scfg), .coarse_i(coarse),
      .ext_clk_sel_i(ext_sel), .ext_clk_i(ext_clk), .qual_i(qual),
      .arm_wait_i(arm_wait), .start_i(start), .stop_i(stop),
      .pc_load_i(pc_load), .pc_load_addr_i(load_addr),
      .jump_addr_i(12'h000), .imb_arm_i(imb_arm), .imb_trig_o(imb_trig),
      .marker_o(marker), .data_o(data), .strobe_o(strobe),
      .exp_data_o(exp_data), .running_o(running), .waiting_o(waiting),
      .armed_o(armed), .pc_o(pc), .repeat_left_o(rep_left));

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (error_cnt == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check_vec(input string name, input logic [47:0] exp_v,
                            input logic [47:0] got);
      checked++;
      if (got !== exp_v) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp_v, got);
      end
   endtask

   // Counts minor ticks until the counter leaves old; a hang ends the run.
   task automatic wait_pc(input logic [PC_W-1:0] old, output int cnt);
      cnt = 0;
      do begin
         @(negedge ref_clk);
         cnt++;
         if (cnt > 60) begin
            error_cnt++;
            report_and_stop();
         end
      end while (pc === old);
   endtask

   // Pulses pc_load (0), start (1) or stop (2) for one cycle.
   task automatic pulse(input int sel);
      @(posedge ref_clk);
      case (sel)
         0: pc_load <= 1'b1;
         1: start <= 1'b1;
         default: stop <= 1'b1;
      endcase
      @(posedge ref_clk);
      {pc_load, start, stop} <= 3'b000;
      @(negedge ref_clk);
   endtask

   task automatic load_pc(input logic [PC_W-1:0] a);
      load_addr <= a;
      pulse(0);
   endtask

   function automatic pgs_word_t mk(logic [11:0] d, logic [2:0] se,
                                    logic [4:0] op, logic [7:0] p);
      mk = {d, se, op, p};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {pc_load, start, stop, arm_wait, imb_arm, ext_sel, ext_clk, coarse} = '0;
      load_addr = 12'h000;
      qual = 3'h0;
      scfg[0] = '{1'h0, 4'h2, 4'h3};
      scfg[1] = '{1'h0, 4'h0, 4'h0};
      scfg[2] = '{1'h1, 4'h0, 4'h0};
      prog[0] = mk(12'h5a3, 3'h1, 5'h00, 8'h00);
      prog[1] = mk(12'h3c5, 3'h0, 5'h09, 8'h02);
      prog[2] = mk(12'h0f0, 3'h0, 5'h02, 8'h09);
      prog[3] = mk(12'hf0f, 3'h0, 5'h14, 8'h00);
      for (int i = 0; i < 4; i++) begin
         exp_w[i] = {prog[i].data, ~prog[i].data, prog[i].data, ~prog[i].data};
      end
      rstn = 1'b0;
      repeat (6) @(negedge ref_clk);
      check_vec("pc in reset", 48'h0, pc);
      check_vec("data in reset", 48'h0, data);
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         u_pgs_host_model.write_word(i, prog[i], exp_w[i]);
      end
      load_pc(12'h7ff);
      check_vec("loaded pc", 48'h7ff, pc);
      load_pc(12'h000);
      pulse(1);
      check_vec("running", 48'h1, running);
      wait_pc(12'h000, n);
      check_vec("pc step", 48'h1, pc);
      check_vec("data word0", prog[0].data, data);
      check_vec("exp word0", exp_w[0], exp_data);
      hi = 0;
      for (int k = 0; k < 10; k++) begin
         hi += (strobe[0] === 1'b1);
         check_vec("idle strobe", 48'h1, strobe[2]);
         @(negedge ref_clk);
      end
      check_vec("strobe width", 48'h3, hi);
      wait_pc(12'h001, n);
      check_vec("data word1", prog[1].data, data);
      check_vec("marker", 48'h1, marker);
      check_vec("repeat left", 48'h2, rep_left);
      wait_pc(12'h002, n);
      // One tick of the repeated pattern went by in the wait for the counter to leave 1.
      check_vec("repeat ticks", 48'((8'h02 + 1) * STEP_TICKS - 1), n);
      check_vec("data word2", prog[2].data, data);
      repeat (40) @(negedge ref_clk);
      check_vec("wait pc", 48'h3, pc);
      check_vec("waiting", 48'h1, waiting);
      qual <= 3'h1;
      wait_pc(12'h003, n);
      check_vec("data word3", prog[3].data, data);
      check_vec("exp word3", exp_w[3], exp_data);
      check_vec("trig pulse", 48'h1, imb_trig);
      @(negedge ref_clk);
      check_vec("trig end", 48'h0, imb_trig);
      repeat (12) @(negedge ref_clk);
      check_vec("halted", 48'h0, running);
      check_vec("halt pc", 48'h4, pc);
      // Armed start waits for the trigger bus before running.
      load_pc(12'h000);
      arm_wait <= 1'b1;
      pulse(1);
      check_vec("armed", 48'h1, armed);
      check_vec("not running", 48'h0, running);
      imb_arm <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check_vec("armed run", 48'h1, running);
      pulse(2);
      check_vec("stopped", 48'h0, running);
      {imb_arm, arm_wait} <= 2'b00;
      // External clock: only its rising edges step the counter.
      ext_sel <= 1'b1;
      load_pc(12'h000);
      pulse(1);
      repeat (30) @(negedge ref_clk);
      check_vec("ext idle pc", 48'h0, pc);
      ext_clk <= 1'b1;
      wait_pc(12'h000, n);
      check_vec("ext step", 48'h1, pc);
      check_vec("ext delay", 48'h1, n < 4);
      ext_clk <= 1'b0;
      load_pc(12'h0aa);
      check_vec("load refused", 48'h1, pc);
      pulse(2);
      // Coarse phase: each strobe unit spans two minor ticks.
      ext_sel <= 1'b0;
      coarse <= 1'b1;
      scfg[0] <= '{1'h0, 4'h1, 4'h2};
      load_pc(12'h000);
      pulse(1);
      wait_pc(12'h000, n);
      hi = 0;
      for (int k = 0; k < 10; k++) begin
         hi += (strobe[0] === 1'b1);
         @(negedge ref_clk);
      end
      check_vec("coarse width", 48'h4, hi);
      pulse(2);
      report_and_stop();
   end
endmodule

// ==== src/pgs_expansion.sv ====
// One expansion card: program data only, stepping under master control.
// Assumes the host writes its memory only while the sequencer is idle.
`timescale 1ns/1ps
module pgs_expansion
   import pgs_pkg::*;
#(
   parameter int DEPTH = MEM_DEPTH,
   parameter int WIDTH = EXP_DATA_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [PC_W-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire pgs_step_ctl_t ctl_i,
   output logic [PC_W-1:0] pc_o,
   output logic [WIDTH-1:0] data_o
);

   initial begin
      if (DEPTH > (1 << PC_W) || WIDTH % 4 != 0) begin
         $error("Expansion depth or width not supported.");
      end
   end

   // Twelve four-bit wide slices share one address.
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // The counter moves only when the master says so.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_o <= PC_RST;
      end else if (ctl_i.load) begin
         pc_o <= ctl_i.addr;
      end else if (ctl_i.fetch) begin
         pc_o <= pc_o + 12'h001;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o <= '0;
      end else if (ctl_i.fetch) begin
         data_o <= mem_q[pc_o];
      end
   end

endmodule

// ==== src/pgs_pkg.sv ====
// Shared constants, microword layout and control carriers of the sequencer.
// Assumes one master clock domain; all users import the whole package.
package pgs_pkg;

   localparam int PC_W = 12;
   localparam int MEM_DEPTH = 4096;
   localparam int DATA_W = 12;
   localparam int STB_N = 3;
   localparam int PARAM_W = 8;
   localparam int EXP_DATA_W = 48;
   localparam int EXP_MAX = 4;
   localparam int PHASE_W = 4;
   localparam int STEP_TICKS = 10;
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
   localparam logic [PARAM_W-1:0] CNT_RST = 8'h00;

   // Two encoded opcode bits select the instruction.
   localparam logic [1:0] OP_NEXT = 2'h0;
   localparam logic [1:0] OP_REPEAT = 2'h1;
   localparam logic [1:0] OP_WAIT = 2'h2;
   localparam logic [1:0] OP_JUMP = 2'h3;

   // Wait parameter: low three bits are the level, next three the mask.
   localparam int WAIT_LVL_LSB = 0;
   localparam int WAIT_MSK_LSB = 3;

   typedef struct packed {
      logic halt;
      logic marker;
      logic trig;
      logic [1:0] sel;
   } pgs_opcode_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [STB_N-1:0] strobe_en;
      pgs_opcode_t opcode;
      logic [PARAM_W-1:0] param;
   } pgs_word_t;

   typedef struct packed {
      logic polarity;
      logic [PHASE_W-1:0] delay;
      logic [PHASE_W-1:0] width;
   } pgs_strobe_cfg_t;

   // Step control fanned out from the master to every expansion card.
   typedef struct packed {
      logic fetch;
      logic load;
      logic [PC_W-1:0] addr;
   } pgs_step_ctl_t;

   typedef enum logic [1:0] {
      PGS_IDLE = 2'b00,
      PGS_ARMED = 2'b01,
      PGS_RUN = 2'b11
   } pgs_state_t;

endpackage

// ==== src/pgs_sequencer.sv ====
// Master sequencer: program memory, counter, decode, clocks and outputs.
// Assumes every input is synchronous to ref_clk_i, which is the minor
// clock; the master step is derived from it or from the external clock.
`timescale 1ns/1ps
module pgs_sequencer
   import pgs_pkg::*;
#(
   parameter int NUM_EXP = EXP_MAX,
   parameter int TICKS = STEP_TICKS
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic prog_we_i,
   input wire logic [PC_W-1:0] prog_addr_i,
   input wire pgs_word_t prog_wdata_i,
   input wire logic [NUM_EXP-1:0] exp_we_i,
   input wire logic [EXP_DATA_W-1:0] exp_wdata_i,
   input wire pgs_strobe_cfg_t [STB_N-1:0] strobe_cfg_i,
   input wire logic coarse_i,
   input wire logic ext_clk_sel_i,
   input wire logic ext_clk_i,
   input wire logic [STB_N-1:0] qual_i,
   input wire logic arm_wait_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic pc_load_i,
   input wire logic [PC_W-1:0] pc_load_addr_i,
   input wire logic [PC_W-1:0] jump_addr_i,
   input wire logic imb_arm_i,
   output logic imb_trig_o,
   output logic marker_o,
   output logic [DATA_W-1:0] data_o,
   output logic [STB_N-1:0] strobe_o,
   output logic [NUM_EXP*EXP_DATA_W-1:0] exp_data_o,
   output logic running_o,
   output logic waiting_o,
   output logic armed_o,
   output logic [PC_W-1:0] pc_o,
   output logic [PARAM_W-1:0] repeat_left_o
);

   initial begin
      if (NUM_EXP < 1 || NUM_EXP > EXP_MAX) begin
         $error("Between one and four expansion cards are supported.");
      end
      if (TICKS < 2 || TICKS > (1 << PHASE_W)) begin
         $error("Ticks per step out of range.");
      end
   end

   function automatic logic qual_match(input logic [PARAM_W-1:0] p,
                                       input logic [STB_N-1:0] q);
      logic [STB_N-1:0] lvl;
      logic [STB_N-1:0] msk;
      lvl = p[WAIT_LVL_LSB +: STB_N];
      msk = p[WAIT_MSK_LSB +: STB_N];
      return ((q ^ lvl) & msk) == '0;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release.

   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Step timing. Each ref_clk_i cycle is one minor tick; the master step
   // comes one tick after the pre-master tick.

   logic [PHASE_W-1:0] div_q;
   logic [PHASE_W-1:0] phase_q;
   logic ext_prev_q;
   logic pre_step;
   logic step_q;
   logic [STB_N-1:0] qual_q;
   pgs_state_t state_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_clk_i;
         div_q <= (div_q == PHASE_W'(TICKS - 1)) ? '0 : div_q + 4'h1;
      end
   end

   // The external clock, when chosen, takes the place of the divider.
   assign pre_step = ext_clk_sel_i ? (ext_clk_i && !ext_prev_q)
      : (div_q == PHASE_W'(TICKS - 2));

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= 1'b0;
         qual_q <= '0;
      end else begin
         step_q <= pre_step && state_q == PGS_RUN;
         if (pre_step) begin
            qual_q <= qual_i;
         end
      end
   end

   // Strobe phase counts minor ticks, halved when coarse_i is set for fifth-step resolution.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= '0;
      end else if (step_q) begin
         phase_q <= '0;
      end else if (phase_q != '1) begin
         phase_q <= phase_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run control and trigger bus.

   pgs_word_t word_q;
   logic halt_now;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PGS_IDLE;
      end else begin
         case (state_q)
            PGS_IDLE: begin
               if (start_i) begin
                  state_q <= arm_wait_i ? PGS_ARMED : PGS_RUN;
               end
            end
            PGS_ARMED: begin
               if (stop_i) begin
                  state_q <= PGS_IDLE;
               end else if (imb_arm_i) begin
                  state_q <= PGS_RUN;
               end
            end
            PGS_RUN: begin
               if (stop_i || halt_now) begin
                  state_q <= PGS_IDLE;
               end
            end
            default: state_q <= PGS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program memory and sequencing.

   // Storage is flip-flops; a real part would map this onto block RAM.
   pgs_word_t mem_q [MEM_DEPTH];
   logic [PC_W-1:0] pc_q;
   logic [PARAM_W-1:0] cnt_q;
   logic wait_hold;
   logic fetch;
   pgs_step_ctl_t ctl;

   always_ff @(posedge ref_clk_i) begin
      if (prog_we_i) begin
         mem_q[prog_addr_i] <= prog_wdata_i;
      end
   end

   assign wait_hold = word_q.opcode.sel == OP_WAIT
      && !qual_match(word_q.param, qual_q);
   assign halt_now = step_q && word_q.opcode.halt && cnt_q == CNT_RST
      && !wait_hold;
   assign fetch = step_q && cnt_q == CNT_RST && !wait_hold
      && !word_q.opcode.halt;

   always_comb begin
      ctl.fetch = fetch;
      ctl.load = (fetch && mem_q[pc_q].opcode.sel == OP_JUMP)
         || (pc_load_i && state_q != PGS_RUN);
      ctl.addr = fetch ? jump_addr_i : pc_load_addr_i;
   end

   // Counter: asynchronous clear, parallel load, else count on each fetch.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= PC_RST;
      end else if (ctl.load) begin
         pc_q <= ctl.addr;
      end else if (fetch) begin
         pc_q <= pc_q + 12'h001;
      end
   end

   // Data and instruction are latched on the same edge.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= '0;
      end else if (fetch) begin
         word_q <= mem_q[pc_q];
      end else if (state_q == PGS_IDLE && start_i) begin
         // A halt word left from the last run must not end the next one.
         word_q <= '0;
      end
   end

   // Value N keeps the pattern out for N further steps.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_RST;
      end else if (fetch && mem_q[pc_q].opcode.sel == OP_REPEAT) begin
         cnt_q <= mem_q[pc_q].param;
      end else if (step_q && cnt_q != CNT_RST) begin
         cnt_q <= cnt_q - 8'h01;
      end else if (state_q == PGS_IDLE) begin
         cnt_q <= CNT_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, strobes and expansion cards.

   logic [PHASE_W-1:0] strobe_phase;

   assign strobe_phase = coarse_i ? (phase_q >> 1) : phase_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         imb_trig_o <= 1'b0;
         marker_o <= 1'b0;
      end else begin
         imb_trig_o <= fetch && mem_q[pc_q].opcode.trig;
         marker_o <= word_q.opcode.marker;
      end
   end

   assign data_o = word_q.data;
   assign running_o = state_q == PGS_RUN;
   assign armed_o = state_q == PGS_ARMED;
   assign waiting_o = running_o && wait_hold;
   assign pc_o = pc_q;
   assign repeat_left_o = cnt_q;

   logic [PC_W-1:0] exp_pc [NUM_EXP];

   for (genvar s = 0; s < STB_N; s++) begin : g_strobe
      pgs_strobe u_strobe (
         .ref_clk_i(ref_clk_i),
         .rst_n_i(rst_n),
         .step_i(step_q),
         .enable_i(word_q.strobe_en[s]),
         .phase_i(strobe_phase),
         .cfg_i(strobe_cfg_i[s]),
         .strobe_o(strobe_o[s])
      );
   end

   for (genvar e = 0; e < NUM_EXP; e++) begin : g_exp
      pgs_expansion u_exp (
         .ref_clk_i(ref_clk_i),
         .rst_n_i(rst_n),
         .wr_en_i(exp_we_i[e]),
         .wr_addr_i(prog_addr_i),
         .wr_data_i(exp_wdata_i),
         .ctl_i(ctl),
         .pc_o(exp_pc[e]),
         .data_o(exp_data_o[e*EXP_DATA_W +: EXP_DATA_W])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_pc_increment: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      fetch && !ctl.load |=> pc_q == $past(pc_q) + 12'h001)
      else $error("Counter did not advance by one.");

   a_pc_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      ctl.load |=> pc_q == $past(ctl.addr))
      else $error("Counter did not take the loaded address.");

   a_repeat_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      step_q && cnt_q != CNT_RST
      |=> $stable(pc_q) && $stable(word_q))
      else $error("Pattern moved during a repeat.");

   a_repeat_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      fetch && mem_q[pc_q].opcode.sel == OP_REPEAT
      |=> cnt_q == $past(mem_q[pc_q].param))
      else $error("Repeat count not loaded from parameter.");

   a_wait_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      step_q && wait_hold |-> !fetch ##1 $stable(pc_q))
      else $error("Counter moved while a wait was unmet.");

   a_latch_together: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      fetch |=> data_o == $past(mem_q[pc_q].data)
      && word_q.opcode == $past(mem_q[pc_q].opcode))
      else $error("Data and instruction not latched together.");

   a_exp_lockstep: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      exp_pc[0] == pc_q)
      else $error("Expansion counter out of step with master.");

   a_step_spacing: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      step_q && !ext_clk_sel_i |=> !step_q)
      else $error("Master steps back to back on the internal clock.");

   a_arm_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == PGS_ARMED && imb_arm_i && !stop_i |=> running_o)
      else $error("Arm from the trigger bus did not start the run.");

endmodule

// ==== src/pgs_strobe.sv ====
// One strobe channel: places a pulse inside a program step.
// Assumes the phase count restarts at zero with each step pulse.
`timescale 1ns/1ps
module pgs_strobe
   import pgs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic step_i,
   input wire logic enable_i,
   input wire logic [PHASE_W-1:0] phase_i,
   input wire pgs_strobe_cfg_t cfg_i,
   output logic strobe_o
);

   logic active_d;
   logic [PHASE_W:0] stop_w;

   assign stop_w = {1'b0, cfg_i.delay} + {1'b0, cfg_i.width};

   // The enable comes from the microword latched for the current step, so
   // the pulse belongs to the step that carries it, not to the one before.
   always_comb begin
      active_d = enable_i && !step_i
         && ({1'b0, phase_i} >= {1'b0, cfg_i.delay})
         && ({1'b0, phase_i} < stop_w);
   end

   // Polarity, delay and width are per channel.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strobe_o <= 1'b0;
      end else begin
         strobe_o <= active_d ^ cfg_i.polarity;
      end
   end

   a_strobe_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !enable_i |=> strobe_o == $past(cfg_i.polarity))
      else $error("Strobe pulsed while not enabled.");

endmodule
